// ### core/enhanced_cap_cmp_unit_defs.svh
// constants for the enhanced capture/compare/pwm mode control block
`ifndef ENHANCED_CAP_CMP_UNIT_DEFS_SVH
`define ENHANCED_CAP_CMP_UNIT_DEFS_SVH
// Functional notes
// - Mode groups 00, 01 and 10 use output a for capture or compare and hand b, c, d to the port.
// - Pwm with configuration 00 modulates only a; b, c, d go back to the port.
// - Pwm configuration 01 modulates d, holds a active, keeps b and c inactive.
// - Pwm configuration 10 drives a and b as a complementary pair with dead-band.
// - Pwm configuration 11 modulates b, holds c active, keeps a and d inactive.
// - The pwm duty is the duty high register over the two duty low bits; ignored outside pwm.
// - Mode 0000 turns everything off and resets the unit's internal state.
// - Capture on each falling edge (0100), each rising edge (0101), each 4th rising edge (0110).
// - Compare 1000 starts the pin low, sets it high on match and raises the flag.
// - Compare 1001 starts the pin high, clears it on match and raises the flag.
// - Compare 1010 only raises the flag on match; the pin stays with the port.
// - Special-event compare clears the first timer and pulses a trigger on match.
// - Pwm codes 1100..1111 set a/c and b/d polarity as high or low active.
// - Outputs b, c, d take the three shared port pins when the configuration uses them and port_dir_in_in is low.
// - Pwm with two or four outputs disables the parallel slave functions on the port.
// - After reset the shared pwm pins are digital inputs.
//------------------------------------------------------------------
// register map
//------------------------------------------------------------------
`define ADDR_CONTROL      4'h0
`define ADDR_DUTY_HIGH    4'h1
`define ADDR_COMPARE_LO   4'h2
`define ADDR_COMPARE_HI   4'h3
`define ADDR_CAPTURE_LO   4'h4
`define ADDR_CAPTURE_HI   4'h5
`define ADDR_INT_STATUS   4'h6
`define ADDR_INT_MASK     4'h7
`define RST_CONTROL       8'h00
`define RST_BYTE          8'h00
//------------------------------------------------------------------
// field positions
//------------------------------------------------------------------
`define CFG_MSB           7
`define CFG_LSB           6
`define DUTY_LO_MSB       5
`define DUTY_LO_LSB       4
`define MODE_MSB          3
`define MODE_LSB          0
`define IRQ_MATCH_BIT     0
`define IRQ_CAPTURE_BIT   1
`define IRQ_TRIGGER_BIT   2
`define CAPTURE_PRESCALE  2'h3
`endif

// ### core/enhanced_cap_cmp_unit_pkg.sv
// types for the enhanced capture/compare/pwm mode control block
package enhanced_cap_cmp_unit_pkg;
    typedef enum logic [3:0]
    {
        MODE_OFF      = 4'h0,
        MODE_CMP_TOG  = 4'h2,
        MODE_CAP_FALL = 4'h4,
        MODE_CAP_RISE = 4'h5,
        MODE_CAP_RISE4= 4'h6,
        MODE_CAP_R16  = 4'h7,
        MODE_CMP_SET  = 4'h8,
        MODE_CMP_CLR  = 4'h9,
        MODE_CMP_SW   = 4'ha,
        MODE_CMP_EVT  = 4'hb
    } mode_code_type;

    typedef enum logic [3:0]
    {
        ST_OFF     = 4'b0001,
        ST_CAPTURE = 4'b0010,
        ST_COMPARE = 4'b0100,
        ST_PWM     = 4'b1000
    } unit_state_type;

    typedef struct packed
    {
        logic [1:0] bridge_output_config;
        logic [1:0] duty_low_bits;
        logic [3:0] unit_mode_select;
    } ccp_control_type;

    typedef struct packed
    {
        logic a;
        logic b;
        logic c;
        logic d;
    } bridge_pins_type;
endpackage

// ### core/enhanced_cap_cmp_unit_mode_ctrl.sv
// mode decode, capture/compare and pwm output steering
`timescale 1ns/1ps
`include "enhanced_cap_cmp_unit_defs.svh"
module enhanced_cap_cmp_unit_mode_ctrl
    import enhanced_cap_cmp_unit_pkg::*;
(
    input  wire logic            mclk_in,           // 50 mhz system clock
    input  wire logic            arst_n_in,         // async reset, active low
    input  wire logic [3:0]      addr_in,           // register address
    input  wire logic [7:0]      wdata_in,          // write data
    input  wire logic            wr_in,             // write strobe
    input  wire logic            rd_in,             // read strobe
    output logic      [7:0]      rdata_out,         // read data, next cycle
    input  wire logic [15:0]     timer_one_count_in,// first timer count
    input  wire logic [9:0]      pwm_count_in,      // pwm period count
    input  wire logic [7:0]      dead_band_in,      // dead-band delay cycles
    input  wire logic            capture_in,        // capture source pin level
    input  wire logic            port_dir_in_in,    // port input-only state
    output logic                 timer_one_clear_out,// clear first timer
    output logic                 special_trigger_out,// special event pulse
    output bridge_pins_type      pin_out,           // pin output levels
    output bridge_pins_type      pin_oe_out,        // pin output enables
    output logic                 parallel_slave_disable_out, // port slave off
    output logic                 unit_int_flag_out  // level interrupt
);
    //------------------------------------------------------------------
    // registers
    //------------------------------------------------------------------
    ccp_control_type ccp_control_q;
    logic [7:0]      duty_high_reg_q;
    logic [15:0]     compare_q;
    logic [15:0]     capture_q;
    logic [2:0]      status_q;
    logic [2:0]      mask_q;
    logic [7:0]      rdata_q;
    logic            cmp_pin_q;
    logic            cap_prev_q;
    logic [3:0]      edge_cnt_q;
    logic            match_prev_q;
    logic            pwm_raw_q;
    logic [7:0]      db_cnt_q;
    logic            pwm_a_q;
    logic            pwm_b_q;
    logic            trigger_q;
    unit_state_type  state_q;
    unit_state_type  state_d;

    logic [3:0] mode;
    logic [1:0] cfg;
    logic       is_pwm;
    logic       is_cmp;
    logic       is_cap;
    logic       match;
    logic       match_edge;
    logic       cap_event;
    logic       rise;
    logic       fall;
    logic [9:0] duty;

    function automatic logic [1:0] mode_group(input logic [3:0] m);
        mode_group = m[`MODE_MSB:2];
    endfunction

    assign mode   = ccp_control_q.unit_mode_select;
    assign cfg    = ccp_control_q.bridge_output_config;
    assign is_pwm = (mode_group(mode) == 2'h3);
    assign is_cmp = (mode_group(mode) == 2'h2) || (mode == MODE_CMP_TOG);
    assign is_cap = (mode_group(mode) == 2'h1);

    //------------------------------------------------------------------
    // unit state
    //------------------------------------------------------------------
    always_comb
    begin
        case (1'b1)
            is_pwm:  state_d = ST_PWM;
            is_cmp:  state_d = ST_COMPARE;
            is_cap:  state_d = ST_CAPTURE;
            default: state_d = ST_OFF;
        endcase
    end

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            state_q <= ST_OFF;
        else
            state_q <= state_d;
    end

    //------------------------------------------------------------------
    // register writes
    //------------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            ccp_control_q   <= `RST_CONTROL;
            duty_high_reg_q <= `RST_BYTE;
            compare_q       <= {`RST_BYTE, `RST_BYTE};
            mask_q          <= 3'h0;
        end
        else if (wr_in)
        begin
            case (addr_in)
                `ADDR_CONTROL:    ccp_control_q      <= wdata_in;
                `ADDR_DUTY_HIGH:  duty_high_reg_q    <= wdata_in;
                `ADDR_COMPARE_LO: compare_q[7:0]     <= wdata_in;
                `ADDR_COMPARE_HI: compare_q[15:8]    <= wdata_in;
                `ADDR_INT_MASK:   mask_q             <= wdata_in[2:0];
                default: ;
            endcase
        end
    end

    //------------------------------------------------------------------
    // reads, status clears on read
    //------------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            rdata_q <= 8'h00;
        else if (rd_in)
        begin
            case (addr_in)
                `ADDR_CONTROL:    rdata_q <= ccp_control_q;
                `ADDR_DUTY_HIGH:  rdata_q <= duty_high_reg_q;
                `ADDR_COMPARE_LO: rdata_q <= compare_q[7:0];
                `ADDR_COMPARE_HI: rdata_q <= compare_q[15:8];
                `ADDR_CAPTURE_LO: rdata_q <= capture_q[7:0];
                `ADDR_CAPTURE_HI: rdata_q <= capture_q[15:8];
                `ADDR_INT_STATUS: rdata_q <= {5'h00, status_q};
                `ADDR_INT_MASK:   rdata_q <= {5'h00, mask_q};
                default:          rdata_q <= 8'h00;
            endcase
        end
        else
            rdata_q <= 8'h00;
    end
    assign rdata_out = rdata_q;

    //------------------------------------------------------------------
    // capture
    //------------------------------------------------------------------
    assign rise = capture_in && !cap_prev_q;
    assign fall = !capture_in && cap_prev_q;

    always_comb
    begin
        case (mode)
            MODE_CAP_FALL:  cap_event = fall;
            MODE_CAP_RISE:  cap_event = rise;
            MODE_CAP_RISE4: cap_event = rise && (edge_cnt_q[1:0] == `CAPTURE_PRESCALE);
            MODE_CAP_R16:   cap_event = rise && (edge_cnt_q == 4'hf);
            default:        cap_event = 1'b0;
        endcase
    end

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cap_prev_q <= 1'b0;
            edge_cnt_q <= 4'h0;
            capture_q  <= 16'h0000;
        end
        else
        begin
            cap_prev_q <= capture_in;
            if (!is_cap)
                edge_cnt_q <= 4'h0;
            else if (rise)
                edge_cnt_q <= edge_cnt_q + 4'h1;
            if (cap_event)
                capture_q <= timer_one_count_in;
        end
    end

    //------------------------------------------------------------------
    // compare
    //------------------------------------------------------------------
    assign match      = is_cmp && (timer_one_count_in == compare_q);
    assign match_edge = match && !match_prev_q;

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            match_prev_q <= 1'b0;
            cmp_pin_q    <= 1'b0;
            trigger_q    <= 1'b0;
        end
        else
        begin
            match_prev_q <= match;
            trigger_q    <= match_edge && (mode == MODE_CMP_EVT);
            if (wr_in && addr_in == `ADDR_CONTROL)
                cmp_pin_q <= (wdata_in[3:0] == MODE_CMP_CLR);
            else if (match_edge && mode == MODE_CMP_SET)
                cmp_pin_q <= 1'b1;
            else if (match_edge && mode == MODE_CMP_CLR)
                cmp_pin_q <= 1'b0;
            else if (match_edge && mode == MODE_CMP_TOG)
                cmp_pin_q <= !cmp_pin_q;
        end
    end
    assign timer_one_clear_out = trigger_q;
    assign special_trigger_out = trigger_q;

    //------------------------------------------------------------------
    // interrupt status, set wins over read clear
    //------------------------------------------------------------------
    logic [2:0] events;
    assign events = {trigger_q, cap_event, match_edge};

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            status_q <= 3'h0;
        else if (state_q == ST_OFF)
            status_q <= 3'h0;
        else if (rd_in && addr_in == `ADDR_INT_STATUS)
            status_q <= events;
        else
            status_q <= status_q | events;
    end
    assign unit_int_flag_out = |(status_q & mask_q);

    //------------------------------------------------------------------
    // pwm with dead-band
    //------------------------------------------------------------------
    assign duty = {duty_high_reg_q, ccp_control_q.duty_low_bits};

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            pwm_raw_q <= 1'b0;
            db_cnt_q  <= 8'h00;
            pwm_a_q   <= 1'b0;
            pwm_b_q   <= 1'b0;
        end
        else if (!is_pwm)
        begin
            pwm_raw_q <= 1'b0;
            db_cnt_q  <= 8'h00;
            pwm_a_q   <= 1'b0;
            pwm_b_q   <= 1'b0;
        end
        else
        begin
            pwm_raw_q <= (pwm_count_in < duty);
            if (pwm_raw_q != pwm_a_q && pwm_raw_q == pwm_b_q)
            begin
                // both off through the dead band, then the new side on
                pwm_a_q <= 1'b0;
                pwm_b_q <= 1'b0;
                db_cnt_q <= dead_band_in;
            end
            else if (db_cnt_q != 8'h00)
                db_cnt_q <= db_cnt_q - 8'h01;
            else
            begin
                pwm_a_q <= pwm_raw_q;
                pwm_b_q <= !pwm_raw_q;
            end
        end
    end

    //------------------------------------------------------------------
    // output steering and polarity
    //------------------------------------------------------------------
    logic act_ac;
    logic act_bd;
    bridge_pins_type lvl;
    bridge_pins_type use_pin;
    assign act_ac = !mode[1];
    assign act_bd = !mode[0];

    always_comb
    begin
        lvl     = '0;
        use_pin = '0;
        if (is_pwm)
        begin
            case (cfg)
                2'h0:
                begin
                    lvl.a     = pwm_raw_q;
                    use_pin   = 4'b1000;
                end
                2'h1:
                begin
                    lvl       = {1'b1, 1'b0, 1'b0, pwm_raw_q};
                    use_pin   = 4'b1111;
                end
                2'h2:
                begin
                    lvl.a     = pwm_a_q;
                    lvl.b     = pwm_b_q;
                    use_pin   = 4'b1100;
                end
                default:
                begin
                    lvl       = {1'b0, pwm_raw_q, 1'b1, 1'b0};
                    use_pin   = 4'b1111;
                end
            endcase
        end
        else if (is_cmp && mode != MODE_CMP_SW && mode != MODE_CMP_EVT)
        begin
            lvl.a     = cmp_pin_q;
            use_pin.a = 1'b1;
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            pin_out    <= '0;
            pin_oe_out <= '0;
            parallel_slave_disable_out <= 1'b0;
        end
        else
        begin
            pin_out.a  <= is_pwm ? (lvl.a ~^ act_ac) : lvl.a;
            pin_out.c  <= is_pwm ? (lvl.c ~^ act_ac) : 1'b0;
            pin_out.b  <= is_pwm ? (lvl.b ~^ act_bd) : 1'b0;
            pin_out.d  <= is_pwm ? (lvl.d ~^ act_bd) : 1'b0;
            pin_oe_out <= use_pin & {1'b1, {3{!port_dir_in_in}}};
            parallel_slave_disable_out <= is_pwm && (cfg != 2'h0);
        end
    end

    //------------------------------------------------------------------
    // assertions
    //------------------------------------------------------------------
    sequence cmp_hit_s;
        match_edge && mode == MODE_CMP_SET && !(wr_in && addr_in == `ADDR_CONTROL);
    endsequence

    AST_CMP_SET: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        cmp_hit_s |=> cmp_pin_q && status_q[`IRQ_MATCH_BIT])
        else $error("compare set mode did not raise pin and flag");
    AST_CMP_CLR: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        match_edge && mode == MODE_CMP_CLR && !wr_in |=> !cmp_pin_q)
        else $error("compare clear mode did not drop pin");
    AST_SW_ONLY: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        mode == MODE_CMP_SW && $stable(mode) |=> !pin_oe_out.a)
        else $error("software compare drove the pin");
    AST_EVT: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        match_edge && mode == MODE_CMP_EVT |=> timer_one_clear_out && special_trigger_out)
        else $error("special event missing");
    AST_OFF: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        state_q == ST_OFF |=> status_q == 3'h0)
        else $error("off mode kept status");
    AST_PSP: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        is_pwm && cfg != 2'h0 |=> parallel_slave_disable_out)
        else $error("parallel slave not disabled");
    AST_SINGLE: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        is_pwm && cfg == 2'h0 |=> pin_oe_out[2:0] == 3'h0)
        else $error("single output drove b c d");
    AST_FWD: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        is_pwm && cfg == 2'h1 && mode == 4'hc |=> pin_out.a && !pin_out.b && !pin_out.c)
        else $error("forward bridge levels wrong");
    AST_REV: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        is_pwm && cfg == 2'h3 && mode == 4'hc |=> pin_out.c && !pin_out.a && !pin_out.d)
        else $error("reverse bridge levels wrong");
    AST_HALF: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        !(pwm_a_q && pwm_b_q))
        else $error("half bridge overlap");
endmodule // enhanced_cap_cmp_unit_mode_ctrl

// ### verif/bridge_source_model.sv
// timer and capture source model facing the mode control block
`timescale 1ns/1ps
module bridge_source_model
(
    input  wire logic        mclk_in,         // system clock
    input  wire logic        arst_n_in,       // async reset, active low
    input  wire logic        timer_clear_in,  // clear request from block
    input  wire logic        edge_req_in,     // start one capture pulse
    output logic [15:0]      timer_count_out, // first timer count
    output logic             capture_out      // capture source level
);
    logic [2:0]  pulse_q;
    // timer wraps at 256 so compare matches come quickly
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            timer_count_out <= 16'h0000;
        else if (timer_clear_in)
            timer_count_out <= 16'h0000;
        else
            timer_count_out <= {8'h00, timer_count_out[7:0] + 8'h01};
    end
    // each request gives one high pulse of seven cycles
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            pulse_q <= 3'h0;
        else if (edge_req_in)
            pulse_q <= 3'h7;
        else if (pulse_q != 3'h0)
            pulse_q <= pulse_q - 3'h1;
    end
    assign capture_out = (pulse_q != 3'h0);
endmodule // bridge_source_model

// ### verif/enhanced_ccp_mode_control_tb_top.sv
// testbench for the enhanced ccp mode control block
`timescale 1ns/1ps
`include "enhanced_cap_cmp_unit_defs.svh"
module enhanced_ccp_mode_control_tb_top;
    import enhanced_cap_cmp_unit_pkg::*;
    logic            clk, rst_n, wr, rd, cap, pdir, tclr, trig, psd, irq, req;
    logic [3:0]      addr;
    logic [7:0]      wdata, rdata, v, tv, ev;
    logic [9:0]      pcnt;
    logic [15:0]     tcnt;
    bridge_pins_type pin, oe;
    logic [3:0]      cm [4] = '{4'h8, 4'h9, 4'hb, 4'h2};
    int              num_errors = 0, checks = 0, cyc = 0, ntrig = 0;

    enhanced_cap_cmp_unit_mode_ctrl i_enhanced_cap_cmp_unit_mode_ctrl
    (
        .mclk_in(clk), .arst_n_in(rst_n), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
        .rd_in(rd), .rdata_out(rdata), .timer_one_count_in(tcnt), .pwm_count_in(pcnt),
        .dead_band_in(8'h02), .capture_in(cap), .port_dir_in_in(pdir),
        .timer_one_clear_out(tclr), .special_trigger_out(trig), .pin_out(pin),
        .pin_oe_out(oe), .parallel_slave_disable_out(psd), .unit_int_flag_out(irq)
    );
    bridge_source_model i_bridge_source_model
    (
        .mclk_in(clk), .arst_n_in(rst_n), .timer_clear_in(tclr), .edge_req_in(req),
        .timer_count_out(tcnt), .capture_out(cap)
    );
    //--------------------------------------------------------------
    // access and check tasks
    //--------------------------------------------------------------
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rchk(input string n, input logic [3:0] a, input logic [7:0] m, e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        v = rdata;
        chk(n, v & m, e);
    endtask
    task automatic pulse();
        @(posedge clk);
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
    endtask
    task automatic wait_irq();
        int k;
        k = 0;
        while (irq !== 1'b1 && k < 600)
        begin
            tick(1);
            k++;
        end
        chk("irq_wait", {7'h0, irq}, 8'h01);
    endtask
    // expected pin levels: act vector {a,b,c,d} then polarity
    function automatic logic [3:0] lvl(input logic [1:0] c, input logic [1:0] p, input logic r);
        logic [3:0] act;
        case (c)
            2'h0:    act = {r, 3'b000};
            2'h1:    act = {1'b1, 2'b00, r};
            2'h2:    act = {r, ~r, 2'b00};
            default: act = {1'b0, r, 2'b10};
        endcase
        return act ^ {p[1], p[0], p[1], p[0]};
    endfunction
    task automatic pwm_case(input logic [1:0] c, input logic [1:0] p, input logic r);
        logic [3:0] eo;
        eo = (c == 2'h0) ? 4'h8 : (c == 2'h2) ? 4'hc : 4'hf;
        wr_reg(`ADDR_CONTROL, {c, 2'b11, 2'b11, p});
        pcnt <= r ? 10'h000 : 10'h3ff;
        tick(12);
        chk("pwm_oe", {4'h0, oe}, {4'h0, eo});
        chk("pwm_lvl", {4'h0, pin & eo}, {4'h0, lvl(c, p, r) & eo});
        chk("pwm_psp", {7'h0, psd}, {7'h0, c != 2'h0});
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    //--------------------------------------------------------------
    // clock, timeout and trigger monitor
    //--------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (trig === 1'b1 && tclr === 1'b1)
            ntrig <= ntrig + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            end_of_test();
        end
    end
    //--------------------------------------------------------------
    // test sequence
    //--------------------------------------------------------------
    initial
    begin
        rst_n = 1'b0;
        addr  = 4'h0;
        wdata = 8'h00;
        wr    = 1'b0;
        rd    = 1'b0;
        pcnt  = 10'h000;
        pdir  = 1'b0;
        req   = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        tick(1);
        chk("oe_reset", {4'h0, oe}, 8'h00);
        wr_reg(`ADDR_CAPTURE_LO, 8'h5a);
        for (int i = 0; i < 8; i++)
            rchk("reg_reset", i[3:0], 8'hff, `RST_BYTE);
        wr_reg(`ADDR_CONTROL, 8'hb6);
        rchk("control_rw", `ADDR_CONTROL, 8'hff, 8'hb6);
        rchk("unmapped", 4'h9, 8'hff, 8'h00);
        $display("test registers done");
        wr_reg(`ADDR_CONTROL, 8'h00);
        wr_reg(`ADDR_COMPARE_LO, 8'h80);
        wr_reg(`ADDR_CONTROL, 8'h0a);
        tick(300);
        chk("oe_soft", {4'h0, oe}, 8'h00);
        chk("irq_masked", {7'h0, irq}, 8'h00);
        wr_reg(`ADDR_INT_MASK, 8'h07);
        tick(2);
        chk("irq_unmasked", {7'h0, irq}, 8'h01);
        rchk("status_soft", `ADDR_INT_STATUS, 8'h01, 8'h01);
        tick(2);
        chk("irq_cleared", {7'h0, irq}, 8'h00);
        $display("test interrupt done");
        foreach (cm[j])
        begin
            wr_reg(`ADDR_CONTROL, 8'h00);
            rchk("status_off", `ADDR_INT_STATUS, 8'hff, 8'h00);
            wr_reg(`ADDR_CONTROL, {4'h0, cm[j]});
            tick(3);
            chk("cmp_oe", {4'h0, oe}, (cm[j] == 4'hb) ? 8'h00 : 8'h08);
            chk("cmp_init", {7'h0, pin.a & oe.a}, {7'h0, cm[j] == 4'h9});
            wait_irq();
            tick(2);
            chk("cmp_final", {7'h0, pin.a & oe.a}, {7'h0, cm[j] == 4'h8 || cm[j] == 4'h2});
            chk("tmr_clear", {7'h0, tcnt < 16'h0008}, {7'h0, cm[j] == 4'hb});
            chk("cmp_psp", {7'h0, psd}, 8'h00);
            v = (cm[j] == 4'hb) ? 8'h04 : 8'h01;
            rchk("status_cmp", `ADDR_INT_STATUS, v, v);
        end
        wr_reg(`ADDR_CONTROL, 8'h00);
        tick(3);
        chk("oe_off", {4'h0, oe}, 8'h00);
        chk("trig_count", ntrig[7:0], 8'h01);
        $display("test compare done");
        for (int k = 4; k < 8; k++)
        begin
            wr_reg(`ADDR_CONTROL, 8'h00);
            wr_reg(`ADDR_CONTROL, k[7:0]);
            rchk("cap_clear", `ADDR_INT_STATUS, 8'hff, 8'h00);
            chk("cap_oe", {4'h0, oe}, 8'h00);
            for (int i = 0; i < ((k == 6) ? 4 : (k == 7) ? 16 : 1); i++)
            begin
                pulse();
                tick(3);
                // timer value at the rising edge, three counts back
                tv = tcnt[7:0] - 8'h03;
                ev = (k == 4 || (k == 6 && i != 3) || (k == 7 && i != 15)) ? 8'h00 : 8'h02;
                rchk("cap_mid", `ADDR_INT_STATUS, 8'h02, ev);
                if (ev == 8'h02)
                    rchk("cap_value", `ADDR_CAPTURE_LO, 8'hff, tv);
                tick(10);
                rchk("cap_end", `ADDR_INT_STATUS, 8'h02, (k == 4) ? 8'h02 : 8'h00);
            end
        end
        $display("test capture done");
        wr_reg(`ADDR_DUTY_HIGH, 8'hff);
        for (int c = 0; c < 4; c++)
            for (int p = 0; p < 4; p++)
                for (int r = 0; r < 2; r++)
                    pwm_case(c[1:0], p[1:0], r[0]);
        @(posedge clk);
        pdir <= 1'b1;
        tick(4);
        chk("oe_port_in", {4'h0, oe}, 8'h08);
        @(posedge clk);
        pdir <= 1'b0;
        wr_reg(`ADDR_DUTY_HIGH, 8'h40);
        wr_reg(`ADDR_CONTROL, 8'h1c);
        for (int n = 0; n < 2; n++)
        begin
            @(posedge clk);
            pcnt <= 10'h100 + n[9:0];
            tick(4);
            chk("duty_edge", {7'h0, pin.a}, {7'h0, n == 0});
        end
        $display("test pwm done");
        end_of_test();
    end
endmodule // enhanced_ccp_mode_control_tb_top
